// ==== ext_irq_pkg.sv ====
// constants and types for the external interrupt latch
//
// How it works
// - falling pin edge sets request latch
// - vector fetch acknowledge clears the latch
// - writing one to ack clears latch
// - ack bit write-only, reads zero
// - reset clears latch even pin low
// - edge-only after reset, level selectable
// - edge mode: hold until acknowledge
// - level mode: pending while pin low
// - reset clears edge/level select bit
// - mask bit withholds request from priority
// - later falling edge sets latch again
// - pending flag ignores mask bit
// - pin level offered as branch condition
// - break with enable: ack clears latch
// - break without enable: ack ignored
// - mask bit read/write, reset clears
// - select bit: 0 edge, 1 edge+level
package ext_irq_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
  localparam int BIT_MODE = 0;
  localparam int BIT_MASK = 1;
  localparam int BIT_ACK = 2;
  localparam int BIT_PENDING = 3;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ==== ext_irq_latch.sv ====
// external interrupt latch with one status and control register
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_latch (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_irq_pin_n,
  input wire logic i_vector_ack,
  input wire logic i_break_state,
  input wire logic i_break_clear_enable,
  input wire ext_irq_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_irq_request,
  output logic o_pin_level
);
  import ext_irq_pkg::*;

  logic rst_s1_q, rst_s2_q;
  logic rstn;
  logic pin_s1_q, pin_s2_q, pin_prev_q;
  logic latch_q, mode_q, mask_q;
  logic wr_sc, soft_ack, any_ack, fall;
  logic level_hold, ack_seen_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rstn = rst_s2_q;

  // no reset: the flops track the pin through reset, so a pin
  // held low across reset gives no false edge at release
  always_ff @(posedge i_clk) begin
    pin_s1_q <= i_irq_pin_n;
    pin_s2_q <= pin_s1_q;
    pin_prev_q <= pin_s2_q;
  end

  assign fall = pin_prev_q & ~pin_s2_q;
  assign wr_sc = i_req.wr && (i_req.addr == STATUS_CONTROL_OFFSET);
  // during break, ack writes only land when clearing is enabled
  assign soft_ack = wr_sc && i_req.wdata[BIT_ACK] &&
                    (!i_break_state || i_break_clear_enable);
  assign any_ack = soft_ack | i_vector_ack;
  assign level_hold = mode_q && !pin_s2_q;

  // level mode: an ack taken while the pin is low waits for the pin to rise
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ack_seen_q <= 1'b0;
    end else if (any_ack && level_hold) begin
      ack_seen_q <= 1'b1;
    end else if (!level_hold) begin
      ack_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= STATUS_CONTROL_RESET[BIT_MODE];
      mask_q <= STATUS_CONTROL_RESET[BIT_MASK];
    end else if (wr_sc) begin
      mode_q <= i_req.wdata[BIT_MODE];
      mask_q <= i_req.wdata[BIT_MASK];
    end
  end

  // new edge beats a same-cycle ack; level mode keeps it while pin low
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= 1'b0;
    end else if (fall || level_hold) begin
      latch_q <= 1'b1;
    end else if (any_ack || ack_seen_q) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd && i_req.addr == STATUS_CONTROL_OFFSET) begin
      o_rdata <= 8'h00;
      o_rdata[BIT_PENDING] <= latch_q;
      o_rdata[BIT_ACK] <= 1'b0;
      o_rdata[BIT_MASK] <= mask_q;
      o_rdata[BIT_MODE] <= mode_q;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_irq_request = latch_q & ~mask_q;
  assign o_pin_level = pin_s2_q;

  // assertions
  property p_fall_sets;
    @(posedge i_clk) disable iff (!rstn) fall |=> latch_q;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("edge did not set latch");

  property p_edge_ack_clears;
    @(posedge i_clk) disable iff (!rstn) (any_ack && !fall && !mode_q) |=> !latch_q;
  endproperty
  a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("ack did not clear");

  property p_level_holds;
    @(posedge i_clk) disable iff (!rstn) (mode_q && !pin_s2_q && latch_q) |=> latch_q;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("level request lost");

  property p_mask;
    @(posedge i_clk) disable iff (!rstn) mask_q |-> !o_irq_request;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request shown");

  property p_break_protect;
    @(posedge i_clk) disable iff (!rstn)
      (i_break_state && !i_break_clear_enable && !i_vector_ack && latch_q) |=> latch_q;
  endproperty
  a_break_protect: assert property (p_break_protect) else $error("break ack took effect");

  property p_ack_reads_zero;
    @(posedge i_clk) disable iff (!rstn) !o_rdata[BIT_ACK] && (o_rdata[7:4] == 4'h0);
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack or unused read one");

  sequence s_read;
    i_req.rd && i_req.addr == STATUS_CONTROL_OFFSET;
  endsequence
  property p_pending_read;
    @(posedge i_clk) disable iff (!rstn) s_read ##0 latch_q |=> o_rdata[BIT_PENDING];
  endproperty
  a_pending_read: assert property (p_pending_read) else $error("pending flag wrong");

  property p_mode_write;
    @(posedge i_clk) disable iff (!rstn) wr_sc |=> mode_q == $past(i_req.wdata[BIT_MODE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not written");

  // acknowledge paths
  property p_vector_ack_clears;
    @(posedge i_clk) disable iff (!rstn)
      (i_vector_ack && !fall && !level_hold) |=> !latch_q;
  endproperty
  a_vector_ack_clears: assert property (p_vector_ack_clears) else $error("vack kept latch");

  property p_soft_ack_clears;
    @(posedge i_clk) disable iff (!rstn)
      (soft_ack && !fall && !level_hold) |=> !latch_q;
  endproperty
  a_soft_ack_clears: assert property (p_soft_ack_clears) else $error("ack write kept latch");

  property p_zero_ack_ignored;
    @(posedge i_clk) disable iff (!rstn)
      (wr_sc && !i_req.wdata[BIT_ACK] && !i_vector_ack && !ack_seen_q && latch_q) |=> latch_q;
  endproperty
  a_zero_ack_ignored: assert property (p_zero_ack_ignored) else $error("zero ack cleared");

  property p_ack_seen_edge_mode;
    @(posedge i_clk) disable iff (!rstn)
      !mode_q |=> !ack_seen_q;
  endproperty
  a_ack_seen_edge_mode: assert property (p_ack_seen_edge_mode) else $error("stale ack kept");

  sequence s_soft_ack;
    soft_ack;
  endsequence
  property p_refire;
    @(posedge i_clk) disable iff (!rstn)
      s_soft_ack ##1 fall |=> latch_q;
  endproperty
  a_refire: assert property (p_refire) else $error("edge after ack lost");

  // register read and write side
  property p_rdata_idle;
    @(posedge i_clk) disable iff (!rstn)
      !(i_req.rd && i_req.addr == STATUS_CONTROL_OFFSET) |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_unmapped_read;
    @(posedge i_clk) disable iff (!rstn)
      (i_req.rd && i_req.addr != STATUS_CONTROL_OFFSET) |=> o_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

  property p_unmapped_write;
    @(posedge i_clk) disable iff (!rstn)
      (i_req.wr && i_req.addr != STATUS_CONTROL_OFFSET) |=> $stable(mode_q) && $stable(mask_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  property p_mask_write;
    @(posedge i_clk) disable iff (!rstn)
      wr_sc |=> mask_q == $past(i_req.wdata[BIT_MASK]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_fields_hold;
    @(posedge i_clk) disable iff (!rstn)
      !wr_sc |=> $stable(mode_q) && $stable(mask_q);
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("control bits moved");

  property p_pending_clear_read;
    @(posedge i_clk) disable iff (!rstn)
      s_read ##0 !latch_q |=> !o_rdata[BIT_PENDING];
  endproperty
  a_pending_clear_read: assert property (p_pending_clear_read) else $error("false pending");

  property p_pending_ignores_mask;
    @(posedge i_clk) disable iff (!rstn)
      s_read ##0 (latch_q && mask_q) |=> o_rdata[BIT_PENDING];
  endproperty
  a_pending_ignores_mask: assert property (p_pending_ignores_mask) else $error("mask hid flag");

  property p_mask_read;
    @(posedge i_clk) disable iff (!rstn)
      s_read |=> o_rdata[BIT_MASK] == $past(mask_q);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_mode_read;
    @(posedge i_clk) disable iff (!rstn)
      s_read |=> o_rdata[BIT_MODE] == $past(mode_q);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  // request output and pin
  property p_request_shown;
    @(posedge i_clk) disable iff (!rstn)
      (latch_q && !mask_q) |-> o_irq_request;
  endproperty
  a_request_shown: assert property (p_request_shown) else $error("request withheld");

  property p_irq_off_when_clear;
    @(posedge i_clk) disable iff (!rstn)
      !latch_q |-> !o_irq_request;
  endproperty
  a_irq_off_when_clear: assert property (p_irq_off_when_clear) else $error("request w/o latch");

  property p_pin_level;
    @(posedge i_clk) disable iff (!rstn)
      o_pin_level == $past(i_irq_pin_n, 2);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  sequence s_pin_fall;
    $fell(i_irq_pin_n);
  endsequence
  property p_pin_to_latch;
    @(posedge i_clk) disable iff (!rstn)
      s_pin_fall |-> ##3 latch_q;
  endproperty
  a_pin_to_latch: assert property (p_pin_to_latch) else $error("pin edge not latched");

  property p_no_spurious_set;
    @(posedge i_clk) disable iff (!rstn)
      (!latch_q && !fall && !level_hold) |=> !latch_q;
  endproperty
  a_no_spurious_set: assert property (p_no_spurious_set) else $error("latch set w/o cause");

  // level mode
  property p_level_sets;
    @(posedge i_clk) disable iff (!rstn)
      level_hold |=> latch_q;
  endproperty
  a_level_sets: assert property (p_level_sets) else $error("low level not pending");

  property p_ack_remembered;
    @(posedge i_clk) disable iff (!rstn)
      (any_ack && level_hold) |=> ack_seen_q;
  endproperty
  a_ack_remembered: assert property (p_ack_remembered) else $error("early ack forgotten");

  property p_ack_then_high;
    @(posedge i_clk) disable iff (!rstn)
      (ack_seen_q && !level_hold && !fall) |=> !latch_q;
  endproperty
  a_ack_then_high: assert property (p_ack_then_high) else $error("pin rise did not clear");

  // break state
  property p_break_clear;
    @(posedge i_clk) disable iff (!rstn)
      (i_break_state && i_break_clear_enable && soft_ack && !fall && !level_hold) |=> !latch_q;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break ack kept latch");

  property p_break_stays_clear;
    @(posedge i_clk) disable iff (!rstn)
      ($fell(i_break_state) && !latch_q && !fall && !level_hold) |=> !latch_q;
  endproperty
  a_break_stays_clear: assert property (p_break_stays_clear) else $error("latch back");

  property p_break_no_ack;
    @(posedge i_clk) disable iff (!rstn)
      (i_break_state && !i_break_clear_enable) |-> !soft_ack;
  endproperty
  a_break_no_ack: assert property (p_break_no_ack) else $error("ack passed in break");

  // state right after reset release
  property p_reset_state;
    @(posedge i_clk) disable iff (!rstn)
      $rose(rstn) |-> (!latch_q && !mode_q && !mask_q);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule
`default_nettype wire

// ==== irq_source.sv ====
// external interrupt source driving the active-low pin
`timescale 1ns/1ns
`default_nettype none
module irq_source (
  input wire logic i_drive_low,
  output logic o_pin_n
);
  // no pull-up: an idle source drives the pin high through the inverter
  assign o_pin_n = ~i_drive_low;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ext_irq_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, low = 1'b0, vack = 1'b0, brk = 1'b0, bce = 1'b0;
  logic pin_n, irq, lvl;
  logic [7:0] rdata;
  reg_req_t req = '0;
  int mismatches = 0;
  int checks_done = 0;
  irq_source irq_source_inst (.i_drive_low(low), .o_pin_n(pin_n));
  ext_irq_latch ext_irq_latch_inst (.i_clk(clk), .i_rstn(rstn), .i_irq_pin_n(pin_n),
    .i_vector_ack(vack), .i_break_state(brk), .i_break_clear_enable(bce),
    .i_req(req), .o_rdata(rdata), .o_irq_request(irq), .o_pin_level(lvl));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, e);
  endtask
  // pin passes two sync stages and an edge stage, so five cycles settle it
  task automatic drive(input logic v);
    @(posedge clk);
    low <= v;
    cyc(5);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_edge;
    drive(1'b1);
    rd(4'h0, 8'h08);
    chk({7'h00, irq}, 8'h01);
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h0A);
    chk({7'h00, irq}, 8'h00);
    wr(4'h0, 8'h06);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h0, 8'h00);
    chk({7'h00, lvl}, 8'h00);
    $display("edge test done");
  endtask
  task automatic t_vack;
    drive(1'b0);
    chk({7'h00, lvl}, 8'h01);
    drive(1'b1);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    #1 chk({7'h00, irq}, 8'h00);
    $display("vector ack test done");
  endtask
  task automatic t_level;
    wr(4'h0, 8'h01);
    cyc(2);
    rd(4'h0, 8'h09);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h09);
    drive(1'b0);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h01);
    $display("level test done");
  endtask
  task automatic t_break;
    wr(4'h0, 8'h00);
    brk <= 1'b1;
    drive(1'b1);
    wr(4'h0, 8'h04);
    rd(4'h0, 8'h08);
    bce <= 1'b1;
    wr(4'h0, 8'h04);
    brk <= 1'b0;
    cyc(2);
    rd(4'h0, 8'h00);
    $display("break test done");
  endtask
  task automatic t_reset;
    wr(4'h0, 8'h03);
    drive(1'b0);
    drive(1'b1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(4);
    rd(4'h0, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("reset test done");
  endtask
  initial begin
    #20000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    cyc(8);
    rstn <= 1'b1;
    cyc(4);
    rd(4'h0, 8'h00);
    chk({7'h00, lvl}, 8'h01);
    t_edge;
    t_vack;
    t_level;
    t_break;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
